// [rtl/psf_pkg.sv]
`default_nettype none
// ==========================================================
// shared constants of the power switch fault control block
// ==========================================================
package psf_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 100;          // 10 MHz

  // documented intervals in nanoseconds
  localparam int DEB_NS      = 1_200_000;      // debounce_interval
  localparam int STO_NS      = 1_090_000_000;  // startup_timeout
  localparam int BLANK_NS    = 24_000_000;     // blanking interval
  localparam int RETRY_NS    = 720_000_000;    // retry delay
  localparam int MINOFF_NS   = 420_000;        // minimum_off_interval
  localparam int REVREC_NS   = 450_000;        // reverse_recovery_interval
  localparam int NFET_ON_NS  = 200_000;        // internal_fet_on_delay
  localparam int PFET_ON_NS  = 1_200_000;      // external_fet_on_delay

  // ns to cycles, rounded up, at least one cycle
  function automatic int psf_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : psf_cycles

  localparam int NFET_ON_CYC = psf_cycles(NFET_ON_NS);

  // timer width
  localparam int CNT_W = 24;

  // apb map (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // control register fields
  localparam int CTRL_SW_OFF = 0;     // forces the switch off
  localparam int CTRL_CLEAR  = 1;     // write 1: clear a latched fault
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status register fields
  localparam int ST_STATE_LSB = 0;    // 10 bits of one-hot state
  localparam int ST_MODE_LSB  = 10;   // 2 bits of mode
  localparam int ST_FLAG      = 12;
  localparam int ST_NFET      = 13;
  localparam int ST_PFET      = 14;

  // current-limit modes, coded as {select2, select1}
  typedef enum logic [1:0] {
    MODE_LATCH = 2'h0,
    MODE_RETRY = 2'h1,
    MODE_CONT  = 2'h2
  } psf_mode_t;

  // sequencer states, one-hot
  typedef enum logic [9:0] {
    ST_OFF      = 10'h001,
    ST_DEB      = 10'h002,
    ST_STARTUP  = 10'h004,
    ST_ON       = 10'h008,
    ST_RETRY    = 10'h010,
    ST_SEVERE   = 10'h020,
    ST_REVREC   = 10'h040,
    ST_REVSTART = 10'h080,
    ST_THERMAL  = 10'h100,
    ST_LATCHED  = 10'h200
  } psf_state_t;

endpackage : psf_pkg
`default_nettype wire

// [rtl/psf_ctrl.sv]
`default_nettype none
// ==========================================================
// power switch fault control
// ==========================================================
// Notes on behaviour
// - switch off only for high-voltage enable high with low-voltage enable low
// - toggling either enable clears a latched fault; controller toggles to recover
// - switch turns on after the debounce interval unless the output is already above undervoltage
// - input falling below undervoltage during debounce abandons the turn-on
// - no debounce when output already above its undervoltage level
// - continuous mode during power-up; selects sampled after startup timeout
// - select pair 00 latch-off, 01 auto-retry, 1x continuous
// - twice-limit overload drops both fets, restarts after at least 420us
// - latch-off: severe overload beyond blanking latches the switch off
// - auto-retry: blanking timer runs during overcurrent, resets on early clear
// - auto-retry: after blanking, retry delay off, then back on
// - flag low whenever the drop exceeds the flag threshold
// - latch-off: overcurrent for blanking latches off until toggle or cycling
// - continuous mode never turns off on overcurrent; flag follows drop
// - reverse current drops both fets for the 450us recovery interval
// - re-enable delays 200us/1.2ms, or 1.4ms/2.4ms with output low
// - after reverse current always restart, whatever the mode
// - slow or fast reverse detector trips the reverse shutdown
// - flag is OR of drop, reverse, heat, grounded pin, undervoltage_lockout, overvoltage_lockout
// - overtemperature drops switch; resumes except latch-off mode
// - auto-retry: after cooling wait the retry delay before turn-on
// - continuous: after cooling turn on after debounce, no retry delay
// - output not charged in startup timeout turns switch off until toggle
// - reverse-protect enable low disables reverse blocking
module psf_ctrl
  import psf_pkg::*;
#(
  parameter int DEB_CYC    = psf_cycles(DEB_NS),
  parameter int STO_CYC    = psf_cycles(STO_NS),
  parameter int BLANK_CYC  = psf_cycles(BLANK_NS),
  parameter int RETRY_CYC  = psf_cycles(RETRY_NS),
  parameter int MINOFF_CYC = psf_cycles(MINOFF_NS),
  parameter int REVREC_CYC = psf_cycles(REVREC_NS),
  parameter int PFET_CYC   = psf_cycles(PFET_ON_NS)
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // enable and select pins
  input  wire logic        high_voltage_enable_n,
  input  wire logic        low_voltage_enable,
  input  wire logic        limit_type_select1,
  input  wire logic        limit_type_select2,
  input  wire logic        reverse_protect_enable,
  // analog comparators
  input  wire logic        in_above_undervoltage_lockout,
  input  wire logic        in_above_overvoltage_lockout,
  input  wire logic        out_above_undervoltage_lockout,
  input  wire logic        out_charged,
  input  wire logic        overcurrent,
  input  wire logic        severe_overcurrent,
  input  wire logic        drop_above_flag,
  input  wire logic        reverse_slow,
  input  wire logic        reverse_fast,
  input  wire logic        overtemp,
  input  wire logic        limit_pin_grounded,
  // gate commands and open-drain flag
  output logic             internal_fet_en,
  output logic             external_fet_en,
  output logic             fault_flag_o,
  output logic             fault_flag_oe
);

  localparam int NSYNC = 16;

  // ========================================================
  // input synchroniser
  // ========================================================
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] prev_q;

  assign raw = {high_voltage_enable_n, low_voltage_enable,
                limit_type_select1, limit_type_select2,
                reverse_protect_enable, in_above_undervoltage_lockout, in_above_overvoltage_lockout,
                out_above_undervoltage_lockout, out_charged, overcurrent,
                severe_overcurrent, drop_above_flag, reverse_slow,
                reverse_fast, overtemp, limit_pin_grounded};

  // two flops per pin, plus a copy for toggle detection
  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  logic high_voltage_enable_n_s, lven_s, sel1_s, sel2_s, reverse_protect_enable_s, in_uv_s, in_ov_s;
  logic out_uv_s, charged_s, oc_s, severe_s, drop_s, rslow_s;
  logic rfast_s, hot_s, limit_setting_pin_s;
  assign {high_voltage_enable_n_s, lven_s, sel1_s, sel2_s, reverse_protect_enable_s, in_uv_s, in_ov_s,
          out_uv_s, charged_s, oc_s, severe_s, drop_s, rslow_s,
          rfast_s, hot_s, limit_setting_pin_s} = sync2_q;

  // ========================================================
  // derived conditions
  // ========================================================
  logic enable_on;
  logic en_toggle;
  logic rev_trip;
  logic go_off;
  logic sw_off;
  logic clear_req;

  assign enable_on = !(high_voltage_enable_n_s && !lven_s);
  assign en_toggle = (high_voltage_enable_n_s != prev_q[NSYNC-1]) ||
                     (lven_s != prev_q[NSYNC-2]);
  assign rev_trip  = reverse_protect_enable_s && (rslow_s || rfast_s);
  assign go_off    = !enable_on || !in_uv_s || in_ov_s ||
                     sw_off || limit_setting_pin_s;

  // ========================================================
  // apb slave: control and status
  // ========================================================
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic        clr_q, clr_d;
  logic        apb_acc;
  psf_state_t  state_q, state_d;
  psf_mode_t   mode_q, mode_d;
  logic        nfet_q, nfet_d, pfet_q, pfet_d, flag_q, flag_d;

  assign apb_acc   = psel && penable;
  assign sw_off    = ctrl_q[CTRL_SW_OFF];
  assign clear_req = clr_q;

  // register decode, answer in the access cycle
  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    clr_d   = 1'b0;
    if (psel && !penable) begin
      if (paddr == ADDR_CTRL) begin
        rdata_d = ctrl_q;
      end else if (paddr == ADDR_STATUS) begin
        rdata_d[ST_STATE_LSB +: 10] = state_q;
        rdata_d[ST_MODE_LSB +: 2]   = mode_q;
        rdata_d[ST_FLAG]            = flag_q;
        rdata_d[ST_NFET]            = nfet_q;
        rdata_d[ST_PFET]            = pfet_q;
      end else begin
        err_d = 1'b1;
      end
    end else if (apb_acc) begin
      rdata_d = rdata_q;
      err_d   = err_q;
    end
    if (apb_acc && pwrite && paddr == ADDR_CTRL) begin
      ctrl_d[CTRL_SW_OFF] = pwdata[CTRL_SW_OFF];
      clr_d               = pwdata[CTRL_CLEAR];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_q  <= CTRL_RESET;
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
      clr_q   <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
      clr_q   <= clr_d;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = rdata_q;
  assign pslverr = apb_acc && err_q;

  // ========================================================
  // sequencer
  // ========================================================
  logic [CNT_W-1:0] cnt_q, cnt_d;    // main interval timer
  logic [CNT_W-1:0] pcnt_q, pcnt_d;  // external fet delay
  logic [CNT_W-1:0] blank_q, blank_d;
  logic             cnt_done;
  logic             blank_done;

  function automatic logic [CNT_W-1:0] load(input int cyc);
    return CNT_W'(cyc - 1);
  endfunction : load

  assign cnt_done   = (cnt_q == '0);
  assign blank_done = (blank_q >= load(BLANK_CYC));

  always_comb begin
    state_d = state_q;
    mode_d  = mode_q;
    cnt_d   = cnt_done ? cnt_q : cnt_q - 1'b1;
    pcnt_d  = (pcnt_q == '0) ? pcnt_q : pcnt_q - 1'b1;
    blank_d = blank_q;
    case (state_q)
      ST_OFF: begin
        mode_d  = MODE_CONT;
        blank_d = '0;
        if (!go_off) begin
          if (out_uv_s) begin
            state_d = ST_STARTUP;
            cnt_d   = load(STO_CYC);
          end else begin
            state_d = ST_DEB;
            cnt_d   = load(DEB_CYC);
          end
        end
      end
      ST_DEB: begin
        if (go_off) begin
          state_d = ST_OFF;
        end else if (cnt_done && !hot_s) begin
          state_d = ST_STARTUP;
          cnt_d   = load(STO_CYC);
        end
      end
      ST_STARTUP, ST_ON: begin
        if (go_off) begin
          state_d = ST_OFF;
        end else if (rev_trip) begin
          state_d = ST_REVREC;
          cnt_d   = load(REVREC_CYC);
        end else if (hot_s) begin
          state_d = (mode_q == MODE_LATCH) ? ST_LATCHED
                                           : ST_THERMAL;
        end else if (severe_s) begin
          state_d = ST_SEVERE;
          cnt_d   = load(MINOFF_CYC);
        end else if (state_q == ST_STARTUP) begin
          if (cnt_done && charged_s) begin
            state_d = ST_ON;
            mode_d  = psf_mode_t'(sel2_s ? MODE_CONT
                                  : {1'b0, sel1_s});
          end else if (cnt_done) begin
            state_d = ST_LATCHED;
          end
        end else if (mode_q == MODE_CONT || !oc_s) begin
          blank_d = '0;
        end else if (blank_done) begin
          blank_d = '0;
          if (mode_q == MODE_LATCH) begin
            state_d = ST_LATCHED;
          end else begin
            state_d = ST_RETRY;
            cnt_d   = load(RETRY_CYC);
          end
        end else begin
          blank_d = blank_q + 1'b1;
        end
      end
      ST_SEVERE: begin
        // blanking keeps running across the short restarts
        if (mode_q != MODE_CONT && !blank_done) begin
          blank_d = blank_q + 1'b1;
        end
        if (go_off) begin
          state_d = ST_OFF;
        end else if (mode_q == MODE_LATCH && blank_done) begin
          state_d = ST_LATCHED;
        end else if (cnt_done && !severe_s) begin
          state_d = ST_ON;
        end
      end
      ST_RETRY: begin
        if (go_off) begin
          state_d = ST_OFF;
        end else if (cnt_done) begin
          state_d = ST_ON;
        end
      end
      ST_THERMAL: begin
        if (go_off) begin
          state_d = ST_OFF;
        end else if (!hot_s) begin
          if (mode_q == MODE_RETRY) begin
            state_d = ST_RETRY;
            cnt_d   = load(RETRY_CYC);
          end else begin
            state_d = ST_DEB;
            cnt_d   = load(DEB_CYC);
          end
        end
      end
      ST_REVREC: begin
        if (go_off) begin
          state_d = ST_OFF;
        end else if (rev_trip) begin
          cnt_d = load(REVREC_CYC);
        end else if (cnt_done) begin
          state_d = ST_REVSTART;
          if (out_uv_s) begin
            cnt_d  = load(NFET_ON_CYC);
            pcnt_d = load(PFET_CYC);
          end else begin
            cnt_d  = load(DEB_CYC + NFET_ON_CYC);
            pcnt_d = load(DEB_CYC + PFET_CYC);
          end
        end
      end
      ST_REVSTART: begin
        if (go_off) begin
          state_d = ST_OFF;
        end else if (rev_trip) begin
          state_d = ST_REVREC;
          cnt_d   = load(REVREC_CYC);
        end else if (cnt_done && pcnt_q == '0) begin
          state_d = ST_STARTUP;
          cnt_d   = load(STO_CYC);
        end
      end
      ST_LATCHED: begin
        if (en_toggle || !in_uv_s || clear_req) begin
          state_d = ST_OFF;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  // gate commands and flag follow the next state
  always_comb begin
    nfet_d = 1'b0;
    pfet_d = 1'b0;
    if (state_d == ST_STARTUP || state_d == ST_ON) begin
      nfet_d = 1'b1;
      pfet_d = 1'b1;
    end else if (state_d == ST_REVSTART) begin
      nfet_d = (cnt_d == '0);
      pfet_d = (pcnt_d == '0);
    end
    flag_d = drop_s || rev_trip || hot_s || limit_setting_pin_s ||
             !in_uv_s || in_ov_s || state_d == ST_REVREC;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= ST_OFF;
      mode_q  <= MODE_CONT;
      cnt_q   <= '0;
      pcnt_q  <= '0;
      blank_q <= '0;
      nfet_q  <= 1'b0;
      pfet_q  <= 1'b0;
      flag_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q  <= mode_d;
      cnt_q   <= cnt_d;
      pcnt_q  <= pcnt_d;
      blank_q <= blank_d;
      nfet_q  <= nfet_d;
      pfet_q  <= pfet_d;
      flag_q  <= flag_d;
    end
  end

  // outputs
  assign internal_fet_en = nfet_q;
  assign external_fet_en = pfet_q;
  assign fault_flag_o    = 1'b0;      // open drain pulls low only
  assign fault_flag_oe   = flag_q;

endmodule : psf_ctrl
`default_nettype wire

// [tb/psf_ctrl_checker.sv]
`default_nettype none
// ==========================================================
// port checker of the power switch fault control
// ==========================================================
module psf_ctrl_checker (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // pins and comparators
  input wire logic high_voltage_enable_n,
  input wire logic low_voltage_enable,
  input wire logic reverse_protect_enable,
  input wire logic in_above_undervoltage_lockout,
  input wire logic severe_overcurrent,
  input wire logic drop_above_flag,
  input wire logic reverse_slow,
  input wire logic reverse_fast,
  input wire logic overtemp,
  // gate commands and flag
  input wire logic internal_fet_en,
  input wire logic external_fet_en,
  input wire logic fault_flag_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // run length of severe overload, saturating
  logic [2:0] sev_run_d;
  logic [2:0] sev_run_q;
  always_comb begin
    sev_run_d = 3'h0;
    if (severe_overcurrent) begin
      sev_run_d = (sev_run_q == 3'h7) ? 3'h7 : sev_run_q + 3'h1;
    end
  end
  always_ff @(posedge clock) begin
    sev_run_q <= srst ? 3'h0 : sev_run_d;
  end

  // ========================================================
  // flag causes
  a_flag_drop: assert property (
    drop_above_flag [*4] |=> fault_flag_oe)
    else $error("flag idle with large drop");
  a_flag_undervoltage_lockout: assert property (
    !in_above_undervoltage_lockout [*4] |-> ##1 fault_flag_oe)
    else $error("flag idle below undervoltage");
  a_flag_heat: assert property (
    overtemp [*4] |=> fault_flag_oe)
    else $error("flag idle while hot");

  // ========================================================
  // gate shutdown causes
  a_fet_enable_off: assert property (
    (high_voltage_enable_n && !low_voltage_enable) [*4]
    |=> !internal_fet_en && !external_fet_en)
    else $error("gates on with enables off");
  a_fet_undervoltage_lockout_off: assert property (
    !in_above_undervoltage_lockout [*4] |=> !internal_fet_en)
    else $error("gate on below undervoltage");
  a_fet_severe_off: assert property (
    sev_run_q >= 3'h5 |-> !internal_fet_en && !external_fet_en)
    else $error("gates on during severe overload");
  a_fet_heat_off: assert property (
    overtemp [*4] |=> !internal_fet_en && !external_fet_en)
    else $error("gates on while hot");
  a_fet_rev_off: assert property (
    (reverse_protect_enable && (reverse_fast || reverse_slow)) [*4]
    |=> !internal_fet_en && !external_fet_en)
    else $error("gates on with reverse current");
endmodule : psf_ctrl_checker

bind psf_ctrl psf_ctrl_checker i_psf_ctrl_checker (.*);
`default_nettype wire

// [tb/psf_partner.sv]
`default_nettype none
// ==========================================================
// output node and flag pull-up beside the switch
// ==========================================================
module psf_partner (
  // clock
  input  wire logic clock,
  // gate command and flag drive
  input  wire logic internal_fet_en,
  input  wire logic fault_flag_o,
  input  wire logic fault_flag_oe,
  // load lets the output charge
  input  wire logic charge_ok,
  // output comparators and flag pin
  output logic      out_above_undervoltage_lockout,
  output logic      out_charged,
  output logic      flag_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] volt_q = 5'h00;

  // node charges while the gate conducts, bleeds while off
  always_ff @(posedge clock) begin
    if (internal_fet_en && charge_ok && volt_q != 5'h1F) begin
      volt_q <= volt_q + 5'h01;
    end else if (!internal_fet_en && volt_q != 5'h00) begin
      volt_q <= volt_q - 5'h01;
    end
  end

  // comparators and pulled-up open-drain flag
  assign out_above_undervoltage_lockout = volt_q[4];
  assign out_charged    = (volt_q == 5'h1F);
  assign flag_pin       = fault_flag_oe ? fault_flag_o : 1'b1;
endmodule : psf_partner
`default_nettype wire

// [tb/psf_ctrl_test.sv]
`default_nettype none
// ==========================================================
// testbench of the power switch fault control
// ==========================================================
module psf_ctrl_test
  import psf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEB = 12, STO = 50, BLANK = 20, RETRY = 30;
  logic clock, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic high_voltage_enable_n, low_voltage_enable, reverse_protect_enable;
  logic limit_type_select1, limit_type_select2, overtemp;
  logic in_above_undervoltage_lockout, in_above_overvoltage_lockout, out_above_undervoltage_lockout, out_charged;
  logic overcurrent, severe_overcurrent, drop_above_flag;
  logic reverse_slow, reverse_fast, limit_pin_grounded;
  logic internal_fet_en, external_fet_en, fault_flag_o, fault_flag_oe;
  logic charge_ok, flag_pin;
  int   errors = 0, checks = 0, c;

  // design with short intervals, node model beside it
  psf_ctrl #(.DEB_CYC(DEB), .STO_CYC(STO), .BLANK_CYC(BLANK),
    .RETRY_CYC(RETRY), .MINOFF_CYC(5), .REVREC_CYC(6),
    .PFET_CYC(12)) i_psf_ctrl (.*);
  psf_partner i_psf_partner (.*);

  // clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ========================================================
  // helpers
  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask : cyc

  task automatic look(input string nm, ref logic s, input logic e);
    @(negedge clock);
    chk(nm, 32'(s), 32'(e));
    @(posedge clock);
  endtask : look

  // bounded wait for the gate level, c counts cycles
  task automatic wfet(input logic v, input int lim);
    c = 0;
    checks++;
    @(negedge clock);
    while (internal_fet_en !== v) begin
      c++;
      if (c > lim) begin
        errors++;
        $display("ERROR wait_fet expected %b seen %b", v, internal_fet_en);
        final_report();
      end
      @(negedge clock);
    end
    @(posedge clock);
  endtask : wfet

  // one apb transfer, setup then access until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk("pready", 32'(pready), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) final_report();
  endtask : apb

  task automatic en(input logic h, l);
    @(posedge clock);
    high_voltage_enable_n <= h;
    low_voltage_enable <= l;
  endtask : en

  task automatic toggle;
    en(1'b1, 1'b0);
    cyc(3);
    en(1'b0, 1'b0);
  endtask : toggle

  // restart with a select pair, mode read during and after startup
  task automatic start(input logic s2, s1);
    en(1'b1, 1'b0);
    limit_type_select2 <= s2;
    limit_type_select1 <= s1;
    wfet(1'b0, 20);
    en(1'b0, 1'b0);
    wfet(1'b1, 200);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("mode", 32'(rd[11:10]), 32'(MODE_CONT));
    cyc(STO + 10);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("mode", 32'(rd[11:10]), s2 ? 32'h2 : 32'(s1));
  endtask : start

  // ========================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {high_voltage_enable_n, low_voltage_enable} = 2'h2;
    {limit_type_select1, limit_type_select2, overtemp} = '0;
    {in_above_overvoltage_lockout, overcurrent, severe_overcurrent} = '0;
    {drop_above_flag, reverse_slow, reverse_fast} = '0;
    limit_pin_grounded = 1'b0;
    {reverse_protect_enable, in_above_undervoltage_lockout, charge_ok} = 3'h7;
    srst = 1'b1;
    cyc(20);
    srst <= 1'b0;
    cyc(3);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h0000_0801);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", rd, CTRL_RESET);
    apb(1'b0, 8'h08, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    // debounce, with an input dip inside it
    en(1'b0, 1'b0);
    cyc(6);
    in_above_undervoltage_lockout <= 1'b0;
    cyc(4);
    in_above_undervoltage_lockout <= 1'b1;
    cyc(DEB);
    look("fet", internal_fet_en, 1'b0);
    wfet(1'b1, 60);
    cyc(STO + 10);
    en(1'b1, 1'b0);
    wfet(1'b0, 20);
    en(1'b0, 1'b0);
    wfet(1'b1, DEB - 4);
    // output never charges, then enable toggle
    charge_ok <= 1'b0;
    en(1'b1, 1'b0);
    cyc(40);
    en(1'b0, 1'b0);
    wfet(1'b1, 60);
    wfet(1'b0, STO + 10);
    cyc(30);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("state", 32'(rd[9:0]), 32'(ST_LATCHED));
    charge_ok <= 1'b1;
    toggle();
    wfet(1'b1, 60);
    // enable truth table
    for (int i = 0; i < 4; i++) begin
      en(i[1], i[0]);
      cyc(8);
      wfet(i != 2, 60);
    end
    apb(1'b1, ADDR_CTRL, 32'h1);
    wfet(1'b0, 20);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", rd, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h0);
    wfet(1'b1, 60);
    for (int i = 0; i < 4; i++) start(i[1], i[0]);
    // continuous: limit, flag follows drop, heat, severe
    overcurrent <= 1'b1;
    drop_above_flag <= 1'b1;
    cyc(3 * BLANK);
    look("fet", internal_fet_en, 1'b1);
    look("flag", flag_pin, 1'b0);
    overcurrent <= 1'b0;
    drop_above_flag <= 1'b0;
    cyc(6);
    look("flag", flag_pin, 1'b1);
    overtemp <= 1'b1;
    cyc(8);
    overtemp <= 1'b0;
    wfet(1'b1, RETRY - 2);
    chk("deb", 32'(c >= DEB), 32'h1);
    severe_overcurrent <= 1'b1;
    cyc(6);
    severe_overcurrent <= 1'b0;
    wfet(1'b0, 20);
    wfet(1'b1, 40);
    // one-cycle overload: gate drops one cycle before the on wait starts
    severe_overcurrent <= 1'b1;
    cyc(1);
    severe_overcurrent <= 1'b0;
    wfet(1'b0, 20);
    wfet(1'b1, 40);
    chk("minoff", 32'(c >= 4), 32'h1);
    // auto-retry: early clear, retry cycle, heat
    start(1'b0, 1'b1);
    overcurrent <= 1'b1;
    cyc(BLANK - 6);
    overcurrent <= 1'b0;
    cyc(3);
    overcurrent <= 1'b1;
    cyc(BLANK - 2);
    look("fet", internal_fet_en, 1'b1);
    wfet(1'b0, 20);
    wfet(1'b1, RETRY + 10);
    chk("retry", 32'(c >= RETRY - 1), 32'h1);
    wfet(1'b0, STO + BLANK + 20);
    overcurrent <= 1'b0;
    wfet(1'b1, RETRY + 10);
    overtemp <= 1'b1;
    cyc(8);
    overtemp <= 1'b0;
    wfet(1'b1, RETRY + 20);
    chk("retry", 32'(c >= RETRY), 32'h1);
    // latch-off: overcurrent, heat, reverse restart
    start(1'b0, 1'b0);
    overcurrent <= 1'b1;
    wfet(1'b0, BLANK + 10);
    overcurrent <= 1'b0;
    cyc(40);
    look("fet", internal_fet_en, 1'b0);
    toggle();
    wfet(1'b1, 60);
    cyc(STO + 10);
    overtemp <= 1'b1;
    cyc(8);
    overtemp <= 1'b0;
    cyc(40);
    look("fet", internal_fet_en, 1'b0);
    toggle();
    wfet(1'b1, 60);
    cyc(STO + 10);
    reverse_fast <= 1'b1;
    cyc(6);
    reverse_fast <= 1'b0;
    look("ext", external_fet_en, 1'b0);
    wfet(1'b1, 2100);
    chk("revdly", 32'(c >= 2000), 32'h1);
    look("ext", external_fet_en, 1'b1);
    cyc(STO + 10);
    reverse_protect_enable <= 1'b0;
    reverse_slow <= 1'b1;
    cyc(20);
    look("fet", internal_fet_en, 1'b1);
    reverse_slow <= 1'b0;
    reverse_protect_enable <= 1'b1;
    final_report();
  end
endmodule : psf_ctrl_test
`default_nettype wire
